/* tb_top.sv */
// self-checking bench for the timer prescaler and flag block
// assumes the pin model on the far side and apb traffic from tasks
`timescale 1ns/10ps

module tb_top;
   import tpf_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end

   logic         clk;      // core clock
   logic         rst_n;    // reset, active low
   tpf_apb_req_s req;      // apb request
   tpf_apb_rsp_s rsp;      // apb response
   tpf_evt_s     evt;      // datapath events
   logic [7:0]   ack;      // vector acknowledge
   logic         gie;      // global interrupt enable
   logic [1:0]   pin;
   logic         cap_pin;
   logic         cnt_go;
   logic         cap_go;
   logic [1:0]   tick;
   logic         strobe;
   logic [3:0]   wgm;
   logic [7:0]   irq;
   logic [31:0]  rd;       // last read data
   logic         err;      // last slave error
   int           failures;
   int           check_count;
   int           n0, n1, ns;
   int           div [5] = '{1, 8, 64, 256, 1024};

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   tpf_timer_flags tpf_timer_flags_i (.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
      .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .CNT_EVT_IN(evt),
      .VECTOR_ACK_IN(ack), .GLOBAL_INT_EN_IN(gie),
      .EXT_COUNT_PIN_IN(pin), .CAPTURE_PIN_IN(cap_pin),
      .TIMER_TICK_OUT(tick), .CAPTURE_STROBE_OUT(strobe),
      .WAVEFORM_MODE_OUT(wgm), .IRQ_OUT(irq));

   tpf_pin_model tpf_pin_model_i (.clk_in(clk), .cnt_go_in(cnt_go),
      .cap_go_in(cap_go), .count_pin_out(pin), .capture_pin_out(cap_pin));

   ////////////////////////////////////////////////////////////////////////
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d, 4'hF};
      @(posedge clk);
      req.penable <= 1'b1;
      // no cycle limit here: only the watchdog ends a wait
      do
      begin
         @(posedge clk);
      end
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      `CHK(rsp.pready, 1'b1)
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // clock config word: mode, capture edge, two selects
   function automatic logic [31:0] cfg(input logic [3:0] m, input logic e,
                                       input logic [2:0] c1, c0);
      return {20'h0_0000, m, e, c1, 1'b0, c0};
   endfunction

   // one-cycle event pulse, then settle to a falling edge
   task automatic fire(input tpf_evt_s e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      repeat (3) @(negedge clk);
   endtask

   // counts ticks and capture strobes where outputs are settled
   task automatic count(input int n);
      n0 = 0;
      n1 = 0;
      ns = 0;
      repeat (n)
      begin
         @(negedge clk);
         n0 += (tick[0] === 1'b1);
         n1 += (tick[1] === 1'b1);
         ns += (strobe === 1'b1);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the expected run of about 5400 cycles
   initial
   begin
      #200000;
      failures++;
      report_and_stop();
   end

   initial
   begin
      {rst_n, gie, cnt_go, cap_go, ack} = '0;
      req = '0;
      evt = '0;
      failures = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, TPF_ADDR_GEN_CTL, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, TPF_ADDR_INT_EN, 32'h0000_00FF);
      apb(1'b0, TPF_ADDR_INT_EN, 32'h0);
      `CHK(rd, 32'h0000_0027)
      apb(1'b0, 12'h004, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // overflow flag, gating and both clear paths
      gie <= 1'b1;
      fire('{cnt_wrap: 1'b1, default: 1'b0});
      `CHK(irq, 8'h01)
      @(posedge clk);
      gie <= 1'b0;
      @(negedge clk);
      `CHK(irq, 8'h00)
      apb(1'b1, TPF_ADDR_FLAGS, 32'h0000_00FF);
      apb(1'b0, TPF_ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h0)
      fire('{cnt_wrap: 1'b1, default: 1'b0});
      @(posedge clk);
      ack <= 8'h01;
      @(posedge clk);
      ack <= 8'h00;
      apb(1'b0, TPF_ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h0)
      // overflow event and vector clear in one cycle: the set must win
      @(posedge clk);
      ack <= 8'h01;
      evt <= '{cnt_wrap: 1'b1, default: 1'b0};
      @(posedge clk);
      ack <= 8'h00;
      evt <= '0;
      apb(1'b0, TPF_ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h0000_0001)
      apb(1'b1, TPF_ADDR_FLAGS, 32'h0000_0001);
      // compare flags with timer1 ticking every clock
      apb(1'b1, TPF_ADDR_CLK_CFG, cfg(4'h0, 1'b0, 3'h1, 3'h0));
      fire('{cmp_a_hit: 1'b1, force_a: 1'b1, cmp_b_hit: 1'b1,
             force_b: 1'b1, default: 1'b0});
      apb(1'b0, TPF_ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h0)
      gie <= 1'b1;
      fire('{cmp_a_hit: 1'b1, cmp_b_hit: 1'b1, default: 1'b0});
      `CHK(irq, 8'h06)
      @(posedge clk);
      gie <= 1'b0;
      apb(1'b1, TPF_ADDR_FLAGS, 32'h0000_0006);
      // every prescaler tap, the two timers on mirrored selects (the same tap at select 3)
      for (int k = 1; k <= 5; k++)
      begin
         apb(1'b1, TPF_ADDR_CLK_CFG, cfg(4'h0, 1'b0, 3'(k), 3'(6 - k)));
         count(1024);
         `CHK(n1, 1024 / div[k - 1])
         `CHK(n0, 1024 / div[5 - k])
      end
      apb(1'b1, TPF_ADDR_CLK_CFG, 32'h0);
      count(64);
      `CHK(n0 + n1, 0)
      // sync mode holds the prescaler reset, release restarts it
      apb(1'b1, TPF_ADDR_GEN_CTL, 32'h0000_0081);
      apb(1'b1, TPF_ADDR_CLK_CFG, cfg(4'h0, 1'b0, 3'h2, 3'h1));
      apb(1'b0, TPF_ADDR_GEN_CTL, 32'h0);
      `CHK(rd, 32'h0000_0081)
      count(32);
      `CHK(n0 + n1, 0)
      apb(1'b1, TPF_ADDR_GEN_CTL, 32'h0);
      count(6);
      `CHK(n1, 0)
      count(8);
      `CHK(n1, 1)
      apb(1'b1, TPF_ADDR_GEN_CTL, 32'h0000_0001);
      apb(1'b0, TPF_ADDR_GEN_CTL, 32'h0);
      `CHK(rd, 32'h0)
      // one pin pulse: rising edge for timer1, falling for timer0
      apb(1'b1, TPF_ADDR_CLK_CFG, cfg(4'h0, 1'b0, 3'h7, 3'h6));
      @(posedge clk);
      cnt_go <= 1'b1;
      @(posedge clk);
      cnt_go <= 1'b0;
      count(16);
      `CHK(n1, 1)
      `CHK(n0, 1)
      // capture on a rising pin edge, then capture flag at top
      apb(1'b1, TPF_ADDR_CLK_CFG, cfg(4'h0, 1'b1, 3'h0, 3'h0));
      @(posedge clk);
      cap_go <= 1'b1;
      @(posedge clk);
      cap_go <= 1'b0;
      count(16);
      `CHK(ns, 1)
      apb(1'b0, TPF_ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h0000_0020)
      apb(1'b1, TPF_ADDR_FLAGS, 32'h0000_0020);
      apb(1'b1, TPF_ADDR_CLK_CFG, cfg(4'hC, 1'b0, 3'h0, 3'h0));
      fire('{top_reached: 1'b1, default: 1'b0});
      `CHK(wgm, 4'hC)
      apb(1'b0, TPF_ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h0000_0020)
      report_and_stop();
   end
endmodule // tb_top

/* tpf_pin_model.sv */
// far side of the block: the external count pins and the capture pin
// assumes one-clock request pulses from the bench on the core clock
`timescale 1ns/10ps

module tpf_pin_model
(
   input  wire logic  clk_in,
   input  wire logic  cnt_go_in,
   input  wire logic  cap_go_in,
   output logic [1:0] count_pin_out,
   output logic       capture_pin_out
);
   logic [2:0] cnt_left;   // high cycles left on the count pins
   logic [2:0] cap_left;   // high cycles left on the capture pin

   initial
   begin
      cnt_left = 3'h0;
      cap_left = 3'h0;
   end

   // each high level lasts four core clocks, well below half the core rate
   always @(posedge clk_in)
   begin
      if (cnt_go_in)
         cnt_left <= 3'h4;
      else if (cnt_left != 3'h0)
         cnt_left <= cnt_left - 3'h1;
      if (cap_go_in)
         cap_left <= 3'h4;
      else if (cap_left != 3'h0)
         cap_left <= cap_left - 3'h1;
   end

   // both timers see the same pin waveform
   assign count_pin_out   = {2{cnt_left != 3'h0}};
   assign capture_pin_out = cap_left != 3'h0;
endmodule // tpf_pin_model

/* tpf_pkg.sv */
// shared constants, register map and carrier types for the timer
// prescaler and flag block; assumes a 32-bit apb slave and one clock
package tpf_pkg;

   // register indices, byte address is four times the index
   localparam logic [7:0]  TPF_IDX_FLAGS   = 8'h0B;
   localparam logic [7:0]  TPF_IDX_INT_EN  = 8'h0C;
   localparam logic [7:0]  TPF_IDX_GEN_CTL = 8'h23;
   localparam logic [7:0]  TPF_IDX_CLK_CFG = 8'h30;
   localparam logic [11:0] TPF_ADDR_FLAGS   = {2'b00, TPF_IDX_FLAGS, 2'b00};
   localparam logic [11:0] TPF_ADDR_INT_EN  = {2'b00, TPF_IDX_INT_EN, 2'b00};
   localparam logic [11:0] TPF_ADDR_GEN_CTL = {2'b00, TPF_IDX_GEN_CTL, 2'b00};
   localparam logic [11:0] TPF_ADDR_CLK_CFG = {2'b00, TPF_IDX_CLK_CFG, 2'b00};

   // flag and enable bit positions (same in both registers)
   localparam int          TPF_BIT_CAP  = 5;
   localparam int          TPF_BIT_CMPB = 2;
   localparam int          TPF_BIT_CMPA = 1;
   localparam int          TPF_BIT_OVF  = 0;
   localparam logic [7:0]  TPF_FLAG_MASK = 8'h27;
   localparam logic [7:0]  TPF_FLAG_RST  = 8'h00;
   localparam logic [7:0]  TPF_INT_EN_RST = 8'h00;

   // general control bits
   localparam int          TPF_BIT_SYNC_MODE = 7;
   localparam int          TPF_BIT_PRESC_RST = 0;

   // clock configuration fields
   localparam int          TPF_CFG_CS0_LSB  = 0;
   localparam int          TPF_CFG_CS1_LSB  = 4;
   localparam int          TPF_CFG_EDGE_BIT = 7;
   localparam int          TPF_CFG_WGM_LSB  = 8;
   localparam logic [11:0] TPF_CFG_RST      = 12'h000;

   // clock select encodings
   localparam logic [2:0]  TPF_CS_STOP     = 3'h0;
   localparam logic [2:0]  TPF_CS_DIRECT   = 3'h1;
   localparam logic [2:0]  TPF_CS_DIV8     = 3'h2;
   localparam logic [2:0]  TPF_CS_DIV64    = 3'h3;
   localparam logic [2:0]  TPF_CS_DIV256   = 3'h4;
   localparam logic [2:0]  TPF_CS_DIV1024  = 3'h5;
   localparam logic [2:0]  TPF_CS_EXT_FALL = 3'h6;
   localparam logic [2:0]  TPF_CS_EXT_RISE = 3'h7;

   // prescaler width and waveform modes that matter here
   localparam int          TPF_PRESC_W     = 10;
   localparam logic [3:0]  TPF_WGM_NORMAL  = 4'h0;
   localparam logic [3:0]  TPF_WGM_CTC_A   = 4'h4;
   localparam logic [3:0]  TPF_WGM_CTC_ICR = 4'hC;

   // apb request and response
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } tpf_apb_req_s;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } tpf_apb_rsp_s;

   // events from the counting datapath, all on the core clock
   typedef struct packed {
      logic cmp_a_hit;
      logic cmp_b_hit;
      logic force_a;
      logic force_b;
      logic cnt_wrap;
      logic tov_mode_evt;
      logic top_reached;
   } tpf_evt_s;

   // complete state of the top module
   typedef struct packed {
      logic [1:0]             pin_meta;
      logic [1:0]             pin_sync;
      logic [1:0]             pin_prev;
      logic                   cap_meta;
      logic                   cap_sync;
      logic                   cap_prev;
      logic [TPF_PRESC_W-1:0] presc;
      logic [7:0]             flags;
      logic [7:0]             int_en;
      logic                   sync_mode;
      logic                   presc_rst;
      logic [11:0]            cfg;
      logic                   pend_a;
      logic                   pend_b;
      logic [31:0]            rdata;
      logic                   slverr;
      logic                   cap_strobe;
   } tpf_state_s;

   // icr used as top in waveform modes 8, 10, 12 and 14
   function automatic logic tpf_icr_is_top(input logic [3:0] wgm);
      return wgm[3] & ~wgm[0];
   endfunction

   // overflow follows the plain counter wrap in normal and ctc modes
   function automatic logic tpf_wrap_mode(input logic [3:0] wgm);
      return (wgm == TPF_WGM_NORMAL) || (wgm == TPF_WGM_CTC_A) ||
             (wgm == TPF_WGM_CTC_ICR);
   endfunction

   // address compare shared by setup and access decoding
   function automatic logic tpf_addr_is(input logic [11:0] a,
                                        input logic [11:0] b);
      return a == b;
   endfunction

endpackage

/* tpf_tick_sel.sv */
// per-timer clock source selection from the shared prescaler
// assumes synchronised pin levels and a prescaler count on one clock
`timescale 1ns/10ps

module tpf_tick_sel
(
   input  wire logic [2:0]                     clock_select_in,
   input  wire logic [tpf_pkg::TPF_PRESC_W-1:0] presc_in,
   input  wire logic                           pin_sync_in,
   input  wire logic                           pin_prev_in,
   input  wire logic                           halt_in,
   output logic                                tick_out
);
   import tpf_pkg::*;

   logic tap;   // selected source before the halt gate

   // each timer picks its own tap from the common count
   always_comb
   begin
      tap = 1'b0;
      case (clock_select_in)
         TPF_CS_STOP:     tap = 1'b0;
         TPF_CS_DIRECT:   tap = 1'b1;
         TPF_CS_DIV8:     tap = &presc_in[2:0];
         TPF_CS_DIV64:    tap = &presc_in[5:0];
         TPF_CS_DIV256:   tap = &presc_in[7:0];
         TPF_CS_DIV1024:  tap = &presc_in[9:0];
         // pin edges bypass the divider entirely
         TPF_CS_EXT_FALL: tap = ~pin_sync_in & pin_prev_in;
         TPF_CS_EXT_RISE: tap = pin_sync_in & ~pin_prev_in;
         default:         tap = 1'b0;
      endcase
   end

   // a held prescaler reset halts every source
   assign tick_out = tap & ~halt_in;

endmodule // tpf_tick_sel

/* tpf_timer_flags.sv */
// timer prescaler, external count synchronisers and timer flags
// assumes an apb master on the core clock and a counting datapath
// that reports compare, wrap and top events as one-cycle pulses
//
// Contract
// - enables gate flags with global interrupt enable
// - capture flag on capture edge or top
// - flags clear by vector or write one
// - compare flags set one timer tick late
// - forced compare never sets a flag
// - overflow flag per waveform mode
// - unused flag and enable bits read zero
// - two timers share one prescaler
// - selects 1..5 give direct and divided clocks
// - prescaler runs free of clock select
// - prescaler reset bit resets prescaler
// - reset bit self-clears outside sync mode
// - sync mode holds reset, halting timers
// - count pin synchronised every core clock
// - selects 6 and 7 count falling, rising edges
// - pin to count latency near three cycles
// - external pin clock is never divided
// - select zero stops the timer
// - pin counts even when driven as output
`timescale 1ns/10ps

module tpf_timer_flags
(
   input  wire logic                  CORE_CLK_IN,
   input  wire logic                  RESETN_IN,
   input  wire tpf_pkg::tpf_apb_req_s APB_REQ_IN,
   output tpf_pkg::tpf_apb_rsp_s      APB_RSP_OUT,
   input  wire tpf_pkg::tpf_evt_s     CNT_EVT_IN,
   input  wire logic [7:0]            VECTOR_ACK_IN,
   input  wire logic                  GLOBAL_INT_EN_IN,
   input  wire logic [1:0]            EXT_COUNT_PIN_IN,
   input  wire logic                  CAPTURE_PIN_IN,
   output logic [1:0]                 TIMER_TICK_OUT,
   output logic                       CAPTURE_STROBE_OUT,
   output logic [3:0]                 WAVEFORM_MODE_OUT,
   output logic [7:0]                 IRQ_OUT
);
   import tpf_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // declarations
   ////////////////////////////////////////////////////////////////////

   tpf_state_s  s;          // registered state
   tpf_state_s  next_s;     // next state
   logic [1:0]  tick;       // timer clock enables, timer 0 and 1
   logic [2:0]  cs0;        // clock select of timer 0
   logic [2:0]  cs1;        // clock select of timer 1
   logic [3:0]  wgm;        // waveform mode of timer 1
   logic        setup;      // apb setup phase
   logic        wr_acc;     // apb write completing now
   logic        wr_gen;     // write to general control now
   logic        cap_edge;   // selected edge on capture pin
   logic        icr_top;    // capture register used as top
   logic [7:0]  set_vec;    // hardware set events, flag layout
   logic [7:0]  clr_vec;    // software and vector clears

   assign cs0 = s.cfg[TPF_CFG_CS0_LSB +: 3];
   assign cs1 = s.cfg[TPF_CFG_CS1_LSB +: 3];
   assign wgm = s.cfg[TPF_CFG_WGM_LSB +: 4];
   assign setup  = APB_REQ_IN.psel & ~APB_REQ_IN.penable;
   assign wr_acc = APB_REQ_IN.psel & APB_REQ_IN.penable &
                   APB_REQ_IN.pwrite;
   assign wr_gen = wr_acc & APB_REQ_IN.pstrb[0] &
                   tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_GEN_CTL);

   ////////////////////////////////////////////////////////////////////
   // clock source selection, one per timer
   ////////////////////////////////////////////////////////////////////

   // both timers read the same free-running count
   tpf_tick_sel u_sel0
   (
      .clock_select_in (cs0),
      .presc_in        (s.presc),
      .pin_sync_in     (s.pin_sync[0]),
      .pin_prev_in     (s.pin_prev[0]),
      .halt_in         (s.presc_rst),
      .tick_out        (tick[0])
   );

   tpf_tick_sel u_sel1
   (
      .clock_select_in (cs1),
      .presc_in        (s.presc),
      .pin_sync_in     (s.pin_sync[1]),
      .pin_prev_in     (s.pin_prev[1]),
      .halt_in         (s.presc_rst),
      .tick_out        (tick[1])
   );

   ////////////////////////////////////////////////////////////////////
   // next state
   ////////////////////////////////////////////////////////////////////

   // whole block behaviour in one pass over the state copy
   always_comb
   begin
      next_s   = s;
      set_vec  = 8'h00;
      clr_vec  = 8'h00;
      cap_edge = 1'b0;
      icr_top  = tpf_icr_is_top(wgm);

      // pin synchronisers; the meta stage feeds only the sync stage
      next_s.pin_meta = EXT_COUNT_PIN_IN;
      next_s.pin_sync = s.pin_meta;
      next_s.pin_prev = s.pin_sync;
      next_s.cap_meta = CAPTURE_PIN_IN;
      next_s.cap_sync = s.cap_meta;
      next_s.cap_prev = s.cap_sync;

      // prescaler counts every clock unless its reset bit is set, whatever the selects say
      if (s.presc_rst)
      begin
         next_s.presc = '0;
      end
      else
      begin
         next_s.presc = s.presc + 10'h001;
      end

      // reset bit drops after one cycle unless sync mode holds it
      if (!s.sync_mode)
      begin
         next_s.presc_rst = 1'b0;
      end

      // capture edge, polarity from the config register
      if (s.cfg[TPF_CFG_EDGE_BIT])
      begin
         cap_edge = s.cap_sync & ~s.cap_prev;
      end
      else
      begin
         cap_edge = ~s.cap_sync & s.cap_prev;
      end
      // pin is disconnected while icr defines the top
      next_s.cap_strobe = cap_edge & ~icr_top;
      if (icr_top)
      begin
         set_vec[TPF_BIT_CAP] = CNT_EVT_IN.top_reached;
      end
      else
      begin
         set_vec[TPF_BIT_CAP] = cap_edge;
      end

      // overflow source depends on the waveform mode
      if (tpf_wrap_mode(wgm))
      begin
         set_vec[TPF_BIT_OVF] = CNT_EVT_IN.cnt_wrap;
      end
      else
      begin
         set_vec[TPF_BIT_OVF] = CNT_EVT_IN.tov_mode_evt;
      end

      // a match is remembered and flagged on the next timer tick;
      // forced strobes never arm the pending bit
      if (tick[1])
      begin
         set_vec[TPF_BIT_CMPA] = s.pend_a;
         set_vec[TPF_BIT_CMPB] = s.pend_b;
         next_s.pend_a = CNT_EVT_IN.cmp_a_hit &
                         ~CNT_EVT_IN.force_a;
         next_s.pend_b = CNT_EVT_IN.cmp_b_hit &
                         ~CNT_EVT_IN.force_b;
      end

      // register writes take effect in the access phase
      if (wr_acc && APB_REQ_IN.pstrb[0])
      begin
         if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_FLAGS))
         begin
            clr_vec = APB_REQ_IN.pwdata[7:0];
         end
         else if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_INT_EN))
         begin
            next_s.int_en = APB_REQ_IN.pwdata[7:0] &
                            TPF_FLAG_MASK;
         end
         else if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_GEN_CTL))
         begin
            // writing sync mode low lets the bit self-clear next cycle
            next_s.sync_mode =
               APB_REQ_IN.pwdata[TPF_BIT_SYNC_MODE];
            next_s.presc_rst =
               APB_REQ_IN.pwdata[TPF_BIT_PRESC_RST];
         end
         else if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_CLK_CFG))
         begin
            next_s.cfg[7:0] = APB_REQ_IN.pwdata[7:0];
         end
      end
      // upper config lane carries the waveform mode
      if (wr_acc && APB_REQ_IN.pstrb[1] &&
          tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_CLK_CFG))
      begin
         next_s.cfg[11:8] = APB_REQ_IN.pwdata[11:8];
      end

      // vector entry clears as a write-one would
      clr_vec = clr_vec | VECTOR_ACK_IN;
      // set is applied last so a coincident clear cannot lose it
      next_s.flags = ((s.flags & ~clr_vec) | set_vec) &
                     TPF_FLAG_MASK;

      // read data is fetched in the setup phase so it leaves a flop
      if (setup)
      begin
         next_s.slverr = 1'b0;
         if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_FLAGS))
         begin
            next_s.rdata = {24'h00_0000,
                            s.flags & TPF_FLAG_MASK};
         end
         else if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_INT_EN))
         begin
            next_s.rdata = {24'h00_0000,
                            s.int_en & TPF_FLAG_MASK};
         end
         else if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_GEN_CTL))
         begin
            next_s.rdata = {24'h00_0000, s.sync_mode, 6'h00,
                            s.presc_rst};
         end
         else if (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_CLK_CFG))
         begin
            next_s.rdata = {20'h0_0000, s.cfg};
         end
         else
         begin
            // unmapped: zero data and an error response
            next_s.rdata  = 32'h0000_0000;
            next_s.slverr = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   ////////////////////////////////////////////////////////////////////

   // all state resets to constants
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         s            <= '0;
         s.flags      <= TPF_FLAG_RST;
         s.int_en     <= TPF_INT_EN_RST;
         s.cfg        <= TPF_CFG_RST;
         s.rdata      <= 32'h0000_0000;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   ////////////////////////////////////////////////////////////////////

   // zero-wait slave: every access completes in its first access cycle
   assign APB_RSP_OUT.pready  = 1'b1;
   assign APB_RSP_OUT.prdata  = s.rdata;
   assign APB_RSP_OUT.pslverr = s.slverr;

   assign TIMER_TICK_OUT     = tick;
   assign CAPTURE_STROBE_OUT = s.cap_strobe;
   assign WAVEFORM_MODE_OUT  = wgm;

   // request needs flag, its enable and the global enable
   assign IRQ_OUT = s.flags & s.int_en & TPF_FLAG_MASK &
                    {8{GLOBAL_INT_EN_IN}};

   ////////////////////////////////////////////////////////////////////
   // assertions
   ////////////////////////////////////////////////////////////////////

   a_set_beats_clear: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (set_vec != 8'h00) |=>
         ((s.flags & $past(set_vec)) == $past(set_vec)))
      else $error("hardware flag set was lost");

   a_reserved_read_zero: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (setup && (tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_FLAGS) ||
                 tpf_addr_is(APB_REQ_IN.paddr, TPF_ADDR_INT_EN)))
      |=> (s.rdata[7:6] == 2'b00) && (s.rdata[4:3] == 2'b00))
      else $error("reserved flag or enable bits read nonzero");

   a_presc_autoclear: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (s.presc_rst && !s.sync_mode && !wr_gen) |=>
         (!s.presc_rst && (s.presc == 10'h000)))
      else $error("prescaler reset did not self-clear");

   a_sync_hold: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (s.presc_rst && s.sync_mode && !wr_gen) |=>
         (s.presc_rst && (s.presc == 10'h000) && (tick == 2'b00)))
      else $error("sync mode failed to hold the prescaler");

   a_cmp_flag_late: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      $rose(s.flags[TPF_BIT_CMPA]) |->
         ($past(s.pend_a) && $past(tick[1])))
      else $error("compare flag set without a pending match");

   a_force_no_flag: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (tick[1] && CNT_EVT_IN.force_b) |=> !s.pend_b)
      else $error("forced compare armed the match flag");

   a_irq_gated: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (IRQ_OUT != 8'h00) |->
         (GLOBAL_INT_EN_IN && ((IRQ_OUT & ~s.int_en) == 8'h00)))
      else $error("interrupt request without its enables");

   // a prescaler reset inside the window restarts the count, so only
   // undisturbed windows of eight cycles are held to the period
   a_div8_tap: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (cs1 == TPF_CS_DIV8 && tick[1]) ##1
         (cs1 == TPF_CS_DIV8 && !s.presc_rst) [*8] |-> tick[1])
      else $error("divide by eight tap period is wrong");

   a_stop_no_tick: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (cs0 == TPF_CS_STOP) |-> !tick[0])
      else $error("stopped timer received a tick");

   a_ext_latency: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      ($rose(EXT_COUNT_PIN_IN[1]) && cs1 == TPF_CS_EXT_RISE) |->
         ##2 (tick[1] || s.presc_rst || cs1 != TPF_CS_EXT_RISE))
      else $error("external edge tick came at the wrong cycle");

endmodule // tpf_timer_flags
